// >>> src/hsd_debounce.sv
`timescale 1ns/1ps
// ****************************************************
// one debounce channel: sample on ticks, accept after
// a run of equal samples
// ****************************************************
module hsd_debounce #(
  parameter int W = 2,
  parameter int RUN = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic sample_i,
  input wire logic bypass_i,
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] stable_o,
  output logic change_o
);
  logic [W-1:0] last_reg;
  logic [W-1:0] stable_reg;
  logic [3:0] run_reg;
  logic change_reg;

  assign stable_o = stable_reg;
  assign change_o = change_reg;

  // sample tracker; a differing sample restarts the run
  // equal run accepted
  always_ff @(posedge clk_i)
  begin
    change_reg <= 1'b0;
    if (sys_rst_i || clear_i)
    begin
      last_reg <= '0;
      stable_reg <= '0;
      run_reg <= '0;
    end
    else if (bypass_i)
    begin
      if (raw_i != stable_reg)
        change_reg <= 1'b1;
      stable_reg <= raw_i;
      last_reg <= raw_i;
      run_reg <= '0;
    end
    else if (sample_i)
    begin
      last_reg <= raw_i;
      if (raw_i != last_reg)
        run_reg <= 4'd1;
      else if (run_reg < 4'(RUN - 1))
        run_reg <= run_reg + 4'd1;
      else if (raw_i != stable_reg)
      begin
        stable_reg <= raw_i;
        change_reg <= 1'b1;
      end
    end
  end
endmodule

// >>> src/hsd_pkg.sv
package hsd_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] HSD_REG_CTRL_STATUS = 8'h43; // printed index
  localparam logic [7:0] HSD_REG_IRQ_STATUS = 8'h50;
  localparam logic [7:0] HSD_REG_IRQ_MASK = 8'h51;
  localparam logic [7:0] HSD_CTRL_RESET = 8'h00;

  // field positions within the control and status register
  localparam int HSD_BIT_ENABLE = 7;
  localparam int HSD_RES_LSB = 5;
  localparam int HSD_INS_LSB = 2;
  localparam int HSD_BTN_LSB = 0;

  // detection result codes
  localparam logic [1:0] HSD_RES_NONE = 2'h0;
  localparam logic [1:0] HSD_RES_NO_MIC = 2'h1;
  localparam logic [1:0] HSD_RES_MIC = 2'h3;

  // interrupt status bits
  localparam int HSD_IRQ_INSERT = 0;
  localparam int HSD_IRQ_BUTTON = 1;
  localparam int HSD_IRQ_W = 2;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int HSD_CLK_HZ = 125_000_000;
  localparam int HSD_REF_HZ = 1_000_000;
  localparam int HSD_US_PER_MS = 1000;
  localparam int HSD_SAMPLES = 8; // samples per interval
  localparam int HSD_INS_BASE_MS = 2;
  localparam int HSD_BTN_BASE_MS = 1;
  localparam logic [2:0] HSD_INS_MAX_CODE = 3'h5;
  localparam int HSD_US_TICKS = HSD_REF_HZ / 1_000_000 * HSD_US_PER_MS;
endpackage

// >>> src/hsd_top.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
// What this block does
// - Detection runs only while the enable bit is one.
// - The result reads 01 without microphone, 11 with, never 10.
// - The result reads 00 when no headset is present.
// - Insertion debounce codes 0-5 give 16..512 ms sampled at 2..64 ms.
// - Button debounce codes give none, 8, 16 or 32 ms at 1, 2, 4 ms.
// - All intervals are counted from a 1 MHz reference tick.
module hsd_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ref_tick_i,
  input wire logic jack_present_i,
  input wire logic mic_present_i,
  input wire logic button_i,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic button_o,
  output logic irq_o
);
  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {ref_tick_i, button_i, mic_present_i, jack_present_i};
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  localparam int HSD_IRQ_W = hsd_pkg::HSD_IRQ_W;

  logic enable_reg;
  logic [2:0] ins_sel_reg;
  logic [1:0] btn_sel_reg;
  logic [HSD_IRQ_W-1:0] irq_stat_reg;
  logic [HSD_IRQ_W-1:0] irq_mask_reg;
  logic [HSD_IRQ_W-1:0] irq_event;
  logic [1:0] result;
  logic ack_reg;
  logic wr_en;
  logic [7:0] wd;
  // one wait cycle per access, then answer
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_en = avs_write && ack_reg;
  assign wd = avs_writedata[7:0];

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read || avs_write) && !ack_reg;
  end

  // control fields
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      enable_reg <= hsd_pkg::HSD_CTRL_RESET[hsd_pkg::HSD_BIT_ENABLE];
      ins_sel_reg <= hsd_pkg::HSD_CTRL_RESET[hsd_pkg::HSD_INS_LSB +: 3];
      btn_sel_reg <= hsd_pkg::HSD_CTRL_RESET[hsd_pkg::HSD_BTN_LSB +: 2];
      irq_mask_reg <= '0;
    end
    else if (wr_en)
    begin
      if (avs_address == hsd_pkg::HSD_REG_CTRL_STATUS)
      begin
        enable_reg <= wd[hsd_pkg::HSD_BIT_ENABLE];
        ins_sel_reg <= wd[hsd_pkg::HSD_INS_LSB +: 3];
        btn_sel_reg <= wd[hsd_pkg::HSD_BTN_LSB +: 2];
      end
      if (avs_address == hsd_pkg::HSD_REG_IRQ_MASK)
        irq_mask_reg <= wd[HSD_IRQ_W-1:0];
    end
  end

  // sticky status; a new event beats a write-one clear
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      irq_stat_reg <= '0;
    else if (wr_en && avs_address == hsd_pkg::HSD_REG_IRQ_STATUS)
      irq_stat_reg <= (irq_stat_reg & ~wd[HSD_IRQ_W-1:0]) | irq_event;
    else
      irq_stat_reg <= irq_stat_reg | irq_event;
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // read data, registered; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      avs_readdata <= '0;
    else if (avs_read && !ack_reg)
    begin
      case (avs_address)
        hsd_pkg::HSD_REG_CTRL_STATUS:
          avs_readdata <= {24'h00_0000, enable_reg, result, ins_sel_reg,
            btn_sel_reg};
        hsd_pkg::HSD_REG_IRQ_STATUS:
          avs_readdata <= {30'h0000_0000, irq_stat_reg};
        hsd_pkg::HSD_REG_IRQ_MASK:
          avs_readdata <= {30'h0000_0000, irq_mask_reg};
        default:
          avs_readdata <= '0;
      endcase
    end
  end

  // ****************************************************
  // millisecond time base
  // ****************************************************
  logic tick_d_reg;
  logic us_tick;
  logic [9:0] us_cnt_reg;
  logic [5:0] ms_cnt_reg;
  logic ms_pulse_reg;
  logic [5:0] ins_div;
  logic [5:0] btn_div;
  logic ins_sample;
  logic btn_sample;

  assign us_tick = sync2_reg[3] && !tick_d_reg;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tick_d_reg <= 1'b0;
      us_cnt_reg <= '0;
      ms_pulse_reg <= 1'b0;
      ms_cnt_reg <= '0;
    end
    else
    begin
      tick_d_reg <= sync2_reg[3];
      ms_pulse_reg <= 1'b0;
      if (us_tick)
      begin
        if (us_cnt_reg == 10'(hsd_pkg::HSD_US_TICKS - 1))
        begin
          us_cnt_reg <= '0;
          ms_pulse_reg <= 1'b1;
        end
        else
          us_cnt_reg <= us_cnt_reg + 10'd1;
      end
      if (ms_pulse_reg)
        ms_cnt_reg <= ms_cnt_reg + 6'd1;
    end
  end

  // sample period 2 ms shifted by code
  assign ins_div = 6'(hsd_pkg::HSD_INS_BASE_MS) << ins_sel_reg;
  // sample period 1 ms shifted by code minus one
  assign btn_div = 6'(hsd_pkg::HSD_BTN_BASE_MS) << (btn_sel_reg - 2'd1);
  assign ins_sample = ms_pulse_reg &&
    ((ms_cnt_reg & (ins_div - 6'd1)) == '0);
  assign btn_sample = ms_pulse_reg &&
    ((ms_cnt_reg & (btn_div - 6'd1)) == '0);

  // ****************************************************
  // debounce channels
  // ****************************************************
  logic [1:0] ins_stable;
  logic ins_change;
  logic btn_stable;
  logic btn_change;
  logic ins_ok;

  // reserved codes hold the filter idle
  assign ins_ok = ins_sel_reg <= hsd_pkg::HSD_INS_MAX_CODE;

  // disabled clears and freezes the filters
  hsd_debounce #(
    .W(2),
    .RUN(hsd_pkg::HSD_SAMPLES)
  ) u_ins (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(!enable_reg),
    .sample_i(ins_sample && ins_ok),
    .bypass_i(1'b0),
    .raw_i(sync2_reg[1:0]),
    .stable_o(ins_stable),
    .change_o(ins_change)
  );

  // code zero passes the button straight through
  hsd_debounce #(
    .W(1),
    .RUN(hsd_pkg::HSD_SAMPLES)
  ) u_btn (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(!enable_reg),
    .sample_i(btn_sample),
    .bypass_i(btn_sel_reg == 2'd0),
    .raw_i(sync2_reg[2]),
    .stable_o(btn_stable),
    .change_o(btn_change)
  );

  // mic without jack reads as no headset, so 10 never shows
  assign result = !ins_stable[0] ? hsd_pkg::HSD_RES_NONE :
    (ins_stable[1] ? hsd_pkg::HSD_RES_MIC : hsd_pkg::HSD_RES_NO_MIC);

  assign irq_event = {btn_change, ins_change};
  assign button_o = btn_stable;
endmodule

// >>> tb/hsd_jack_model.sv
`timescale 1ns/1ps
// ****
// jack sense front end and reference tick
// ****
module hsd_jack_model (
  input wire logic clk_i,
  input wire logic plug_i,
  input wire logic mic_i,
  input wire logic press_i,
  input wire logic glitch_i,
  output logic tick_o,
  output logic jack_o,
  output logic mic_o,
  output logic btn_o
);
  initial {tick_o, jack_o, mic_o, btn_o} = 4'h0;
  // sped-up tick
  // one microsecond per two clocks keeps runs short
  always @(posedge clk_i)
    tick_o <= ~tick_o;
  // a bouncing contact flips the raw level every clock
  always @(posedge clk_i)
  begin
    jack_o <= glitch_i ? ~jack_o : plug_i;
    mic_o <= plug_i & mic_i;
    btn_o <= press_i;
  end
endmodule

// >>> tb/hsd_top_sva.sv
`timescale 1ns/1ps
// ****
// port checker for the headset detect block
// ****
module hsd_top_sva (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ref_tick_i,
  input wire logic button_i,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic button_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] ctl_reg, msk_reg;
  logic [15:0] tk_reg;
  logic tk_d_reg, bd_reg;
  wire acc = (avs_read | avs_write) & ~avs_waitrequest;
  wire rdc = acc & avs_read & (avs_address == 8'h43);
  // shadow of written bytes, so reads can be judged
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ctl_reg <= 8'h00;
      msk_reg <= 8'h00;
    end
    else if (acc & avs_write & (avs_address == 8'h43))
      ctl_reg <= avs_writedata[7:0];
    else if (acc & avs_write & (avs_address == 8'h51))
      msk_reg <= avs_writedata[7:0];
  end
  // reference ticks since raw button moved; saturates, never wraps
  always_ff @(posedge clk_i)
  begin
    tk_d_reg <= ref_tick_i;
    bd_reg <= button_i;
    if (sys_rst_i || button_i != bd_reg)
      tk_reg <= 16'h0000;
    else if (ref_tick_i & ~tk_d_reg & ~&tk_reg)
      tk_reg <= tk_reg + 16'h0001;
  end
  property p_wait;
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("second wait state");
  property p_code;
    rdc |-> avs_readdata[6:5] != 2'b10;
  endproperty
  a_code: assert property (p_code) else $error("result 10");
  property p_off;
    rdc && !ctl_reg[7] |-> avs_readdata[6:5] == 2'b00;
  endproperty
  a_off: assert property (p_off) else $error("result while off");
  property p_rb;
    rdc |-> avs_readdata[31:8] == '0 && avs_readdata[7] == ctl_reg[7]
      && avs_readdata[4:0] == ctl_reg[4:0];
  endproperty
  a_rb: assert property (p_rb) else $error("control readback");
  property p_unm;
    acc && avs_read && !(avs_address inside {8'h43, 8'h50, 8'h51})
      |-> avs_readdata == '0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_bfast;
    ctl_reg[7] && ctl_reg[1:0] == 2'b00 && $changed(button_i) ##1
      $stable(button_i) [*8] |-> button_o == button_i;
  endproperty
  a_bfast: assert property (p_bfast) else $error("button slow");
  property p_bslow;
    ctl_reg[7] && ctl_reg[1:0] != 2'b00 && $changed(button_o)
      |-> tk_reg >= (16'h1B4E << (ctl_reg[1:0] - 2'h1));
  endproperty
  a_bslow: assert property (p_bslow) else $error("button early");
  property p_irqm;
    msk_reg[1:0] == 2'h0 && $past(msk_reg[1:0]) == 2'h0 |-> !irq_o;
  endproperty
  a_irqm: assert property (p_irqm) else $error("masked irq");
endmodule
bind hsd_top hsd_top_sva u_hsd_top_sva (.clk_i, .sys_rst_i, .ref_tick_i,
  .button_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .button_o, .irq_o);

// >>> tb/hsd_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
// ****
// bench for the headset detect block
// ****
module hsd_top_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd_q;
  logic avs_waitrequest, button_o, irq_o, ref_tick_i, jack_present_i;
  logic mic_present_i, button_i;
  logic plug = 1'b0, mic = 1'b0, press = 1'b0, glitch = 1'b0;
  int err_total = 0, checked = 0, cyc = 0;
  logic [7:0] v;
  hsd_top u_hsd_top (.clk_i, .sys_rst_i, .ref_tick_i, .jack_present_i,
    .mic_present_i, .button_i, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .button_o, .irq_o);
  hsd_jack_model u_hsd_jack_model (.clk_i, .plug_i(plug), .mic_i(mic),
    .press_i(press), .glitch_i(glitch), .tick_o(ref_tick_i),
    .jack_o(jack_present_i), .mic_o(mic_present_i), .btn_o(button_i));
  always #4 clk_i = ~clk_i;
  task automatic close_out;
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // run of about 73k cycles, so a hang is cut off at cycle 90k
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_total++;
      close_out();
    end
  end
  // one access, held until waitrequest is seen low
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h00_0000, d};
    @(posedge clk_i);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_i);
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // reference result from the debounced plug and mic levels
  function automatic logic [1:0] exp_res(input int j, input int m);
    return j == 0 ? 2'b00 : (m != 0 ? 2'b11 : 2'b01);
  endfunction
  task automatic ctl_chk(input int j, input int m);
    bus(8'h43, 1'b0, 8'h00);
    `CHK("result", {24'h00_0000, 1'b1, exp_res(j, m), 5'h01}, rd_q)
  endtask
  initial
  begin
    v = 8'($urandom(32'h6fbb_4b92));
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(8'h43, 1'b0, 8'h00);
    `CHK("ctrl reset", 32'h0000_0000, rd_q)
    bus(8'h44, 1'b0, 8'h00);
    `CHK("unmapped", 32'h0000_0000, rd_q)
    // every insertion code, reserved too, random button code
    for (int i = 0; i < 8; i++)
    begin
      v = {3'h0, 3'(i), 2'($urandom)};
      bus(8'h43, 1'b1, v);
      bus(8'h43, 1'b0, 8'h00);
      `CHK("ctrl fields", {24'h00_0000, v}, rd_q)
    end
    // no debounce, button irq raised, cleared, masked
    bus(8'h51, 1'b1, 8'h02);
    bus(8'h43, 1'b1, 8'h80);
    press <= 1'b1;
    repeat (40) @(negedge clk_i);
    `CHK("button fast", 1'b1, button_o)
    `CHK("irq raised", 1'b1, irq_o)
    bus(8'h50, 1'b1, 8'h02);
    repeat (2) @(negedge clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    bus(8'h51, 1'b1, 8'h00);
    press <= 1'b0;
    repeat (40) @(negedge clk_i);
    `CHK("button low", 1'b0, button_o)
    `CHK("irq masked", 1'b0, irq_o)
    bus(8'h50, 1'b0, 8'h00);
    `CHK("irq status", 32'h0000_0002, rd_q)
    // bouncing plug with mic, button at 8 ms debounce
    bus(8'h50, 1'b1, 8'h03);
    bus(8'h51, 1'b1, 8'h01);
    bus(8'h43, 1'b1, 8'h81);
    {plug, mic, press, glitch} <= 4'hF;
    repeat (400) @(posedge clk_i);
    glitch <= 1'b0;
    repeat (24000) @(negedge clk_i);
    ctl_chk(0, 0);
    `CHK("button slow", 1'b1, button_o)
    repeat (12000) @(negedge clk_i);
    ctl_chk(1, 1);
    `CHK("insert irq", 1'b1, irq_o)
    @(posedge clk_i);
    mic <= 1'b0;
    repeat (36000) @(negedge clk_i);
    ctl_chk(1, 0);
    bus(8'h43, 1'b1, 8'h00);
    bus(8'h43, 1'b0, 8'h00);
    `CHK("disabled", 32'h0000_0000, rd_q)
    close_out();
  end
endmodule
